// [ptp_trip_top.sv]
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`default_nettype none

// Trip protection for one output pair, Wishbone classic slave.
module ptp_trip_top
  import ptp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ptp_pkg::PTP_N_TRIP-1:0] trip_input_n_i,
  input wire logic [ptp_pkg::PTP_N_EV-1:0] compare_event_i,
  input wire logic [15:0] time_base_counter_i,
  input wire logic pwm_a_i,
  input wire logic pwm_b_i,
  output logic pulse_output_a_o,
  output logic pulse_output_a_oe_n_o,
  output logic pulse_output_b_o,
  output logic pulse_output_b_oe_n_o,
  output logic trip_interrupt_pulse_o,
  output logic cycle_trip_active_o,
  output logic one_shot_trip_active_o
);

  import ptp_pkg::*;

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [PTP_N_TRIP-1:0] trip_s1_ff;
  logic [PTP_N_TRIP-1:0] trip_s2_ff;
  logic [PTP_N_EV-1:0] ev_s1_ff;
  logic [PTP_N_EV-1:0] ev_s2_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trip_s1_ff <= '1;
      trip_s2_ff <= '1;
      ev_s1_ff <= '0;
      ev_s2_ff <= '0;
    end
    else
    begin
      trip_s1_ff <= trip_input_n_i;
      trip_s2_ff <= trip_s1_ff;
      ev_s1_ff <= compare_event_i;
      ev_s2_ff <= ev_s1_ff;
    end
  end

  // ****************************************************
  // Bus slave
  // ****************************************************
  ptp_bus_state_t bus_ff;
  ptp_bus_state_t nxt_bus;
  logic [15:0] select_ff;
  logic [15:0] action_ff;
  logic [15:0] int_en_ff;
  logic [15:0] rd_data;
  logic [31:0] dat_ff;
  logic req;
  logic wr_go;
  logic wr_lo;
  logic wr_hi;
  logic [2:0] idx;
  logic idx_ok;
  logic wr_sel;
  logic wr_act;
  logic wr_ien;
  logic wr_clr;
  logic wr_frc;
  logic [15:0] wmask;
  logic [15:0] clr_bits;
  logic [15:0] frc_bits;

  assign idx = wb_adr_i[4:2];
  assign idx_ok = (idx <= PTP_IDX_FORCE);
  assign req = wb_cyc_i && wb_stb_i && (bus_ff == PTP_BUS_IDLE);
  // Writes land at the edge where the master sees ack, as classic single
  // cycles expect; read data is captured one edge earlier so it stands.
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && (bus_ff == PTP_BUS_ACK);
  assign wr_lo = wr_go && wb_sel_i[0] && idx_ok;
  assign wr_hi = wr_go && wb_sel_i[1] && idx_ok;
  assign wmask = {{8{wr_hi}}, {8{wr_lo}}};
  assign wr_sel = (idx == PTP_IDX_SELECT);
  assign wr_act = (idx == PTP_IDX_ACTION);
  assign wr_ien = (idx == PTP_IDX_INT_EN);
  assign wr_clr = (idx == PTP_IDX_CLEAR);
  assign wr_frc = (idx == PTP_IDX_FORCE);
  // Clear and force are write-one strobes; nothing is stored.
  assign clr_bits = wr_clr ? (wb_dat_i[15:0] & wmask) : 16'h0000;
  assign frc_bits = wr_frc ? (wb_dat_i[15:0] & wmask) : 16'h0000;

  always_comb
  begin
    case (bus_ff)
      PTP_BUS_IDLE: nxt_bus = req ? PTP_BUS_ACK : PTP_BUS_IDLE;
      PTP_BUS_ACK: nxt_bus = PTP_BUS_IDLE;
      default: nxt_bus = PTP_BUS_IDLE;
    endcase
  end

  logic [15:0] flags_ff;

  // Clear and force read back zero; unmapped words read zero too.
  assign rd_data = (idx == PTP_IDX_SELECT) ? select_ff :
                   (idx == PTP_IDX_ACTION) ? action_ff :
                   (idx == PTP_IDX_INT_EN) ? int_en_ff :
                   (idx == PTP_IDX_FLAGS) ? flags_ff : 16'h0000; // [R15]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_ff <= PTP_BUS_IDLE;
      dat_ff <= '0;
      select_ff <= PTP_RST_VAL;
      action_ff <= PTP_RST_VAL;
      int_en_ff <= PTP_RST_VAL;
    end
    else
    begin
      bus_ff <= nxt_bus;
      dat_ff <= req ? {16'h0000, rd_data} : dat_ff;
      if (wr_sel)
        select_ff <= ((select_ff & ~wmask) | (wb_dat_i[15:0] & wmask))
                     & PTP_SEL_MASK; // [R1]
      if (wr_act)
        action_ff <= ((action_ff & ~wmask) | (wb_dat_i[15:0] & wmask))
                     & PTP_ACT_MASK; // [R2]
      if (wr_ien)
        int_en_ff <= ((int_en_ff & ~wmask) | (wb_dat_i[15:0] & wmask))
                     & PTP_INT_EN_MASK; // [R6]
    end
  end

  // The one-hot acknowledge bit of the state register drives the pin.
  assign wb_ack_o = bus_ff[1];
  assign wb_dat_o = dat_ff;

  // ****************************************************
  // Trip detection and latches
  // ****************************************************
  logic [PTP_N_TRIP-1:0] trip_low;
  logic cyc_src;
  logic one_src;
  logic cyc_set;
  logic one_set;
  logic [PTP_N_EV-1:0] ev_set;
  logic cyc_hold_ff;
  logic one_hold_ff;
  logic [PTP_N_EV-1:0] ev_hold_ff;
  logic cnt_zero;
  logic [15:0] nxt_flags;
  logic [PTP_N_EV+2:1] trip_flags;
  logic [PTP_N_EV+2:1] en_flags;
  logic int_fire;
  logic int_pulse_ff;

  assign trip_low = ~trip_s2_ff;
  assign cyc_src = |(trip_low & select_ff[PTP_N_TRIP-1:0]); // [R1]
  assign one_src = |(trip_low
                   & select_ff[PTP_SEL_ONE_LO +: PTP_N_TRIP]); // [R18]
  assign cyc_set = cyc_src || frc_bits[PTP_BIT_CYC]; // [R19]
  assign one_set = one_src || frc_bits[PTP_BIT_ONE]; // [R19]
  assign ev_set = ev_s2_ff
                  | frc_bits[PTP_BIT_EV_LO +: PTP_N_EV]; // [R20]
  assign cnt_zero = (time_base_counter_i == PTP_CNT_ZERO);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cyc_hold_ff <= 1'b0;
      one_hold_ff <= 1'b0;
      ev_hold_ff <= '0;
    end
    else
    begin
      // Released only at counter zero, whatever the flag does.
      cyc_hold_ff <= cyc_set || (cyc_hold_ff && !cnt_zero); // [R10]
      one_hold_ff <= one_set
                     || (one_hold_ff && !clr_bits[PTP_BIT_ONE]); // [R18]
      ev_hold_ff <= ev_set | (ev_hold_ff
                    & ~clr_bits[PTP_BIT_EV_LO +: PTP_N_EV]); // [R15]
    end
  end

  // ****************************************************
  // Flags and interrupt
  // ****************************************************
  // Set always wins over a simultaneous clear.
  always_comb
  begin
    nxt_flags = flags_ff & ~clr_bits & 16'h007f; // [R16] [R17]
    nxt_flags[PTP_BIT_CYC] = cyc_set
                             || nxt_flags[PTP_BIT_CYC]; // [R9]
    nxt_flags[PTP_BIT_ONE] = one_set
                             || nxt_flags[PTP_BIT_ONE]; // [R8]
    nxt_flags[PTP_BIT_EV_LO +: PTP_N_EV] = ev_set
      | nxt_flags[PTP_BIT_EV_LO +: PTP_N_EV]; // [R11]
    nxt_flags[PTP_BIT_INT] = nxt_flags[PTP_BIT_INT] || int_fire; // [R12]
  end

  assign trip_flags = flags_ff[PTP_N_EV+2:1];
  assign en_flags = trip_flags & int_en_ff[PTP_N_EV+2:1]; // [R6] [R7]
  // A pulse fires while an enabled flag is up and the gate is clear,
  // so clearing the gate with flags still up re-fires it.
  assign int_fire = (|en_flags) && !flags_ff[PTP_BIT_INT]; // [R13] [R14]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_ff <= PTP_RST_VAL;
      int_pulse_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      int_pulse_ff <= int_fire; // [R12]
    end
  end

  assign trip_interrupt_pulse_o = int_pulse_ff;
  assign cycle_trip_active_o = cyc_hold_ff;
  assign one_shot_trip_active_o = one_hold_ff;

  // ****************************************************
  // Output actions
  // ****************************************************
  logic trip_any;
  assign trip_any = cyc_hold_ff || one_hold_ff;

  ptp_out_ctl u_out_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pwm_i(pwm_a_i),
    .act_trip_i(action_ff[PTP_ACT_A_LO +: 2]), // [R2]
    .trip_on_i(trip_any),
    .act_ev1_i(action_ff[PTP_ACT_EVA1_LO +: 2]), // [R4]
    .ev1_on_i(ev_hold_ff[0]),
    .act_ev2_i(action_ff[PTP_ACT_EVA2_LO +: 2]), // [R4]
    .ev2_on_i(ev_hold_ff[1]),
    .pin_o(pulse_output_a_o),
    .pin_oe_n_o(pulse_output_a_oe_n_o)
  );

  ptp_out_ctl u_out_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pwm_i(pwm_b_i),
    .act_trip_i(action_ff[PTP_ACT_B_LO +: 2]), // [R3]
    .trip_on_i(trip_any),
    .act_ev1_i(action_ff[PTP_ACT_EVB1_LO +: 2]), // [R5]
    .ev1_on_i(ev_hold_ff[2]),
    .act_ev2_i(action_ff[PTP_ACT_EVB2_LO +: 2]), // [R5]
    .ev2_on_i(ev_hold_ff[3]),
    .pin_o(pulse_output_b_o),
    .pin_oe_n_o(pulse_output_b_oe_n_o)
  );

endmodule

`default_nettype wire

// [ptp_pkg.sv]
//
// Notes on behaviour
// [R1] Select bits 0-5 enable active-low trip inputs 1-6 as cycle-by-cycle.
// [R2] Output A trip action bits 1-0: 00 hi-z, 01 high, 10 low, 11 none.
// [R3] Output B trip action bits 3-2, same four codes as output A.
// [R4] Compare A event 1/2 actions at bits 5-4 and 7-6 act on output A.
// [R5] Compare B event 1/2 actions at bits 9-8 and 11-10 act on output B.
// [R6] Interrupt enable bit 2 one-shot, bit 1 cycle-by-cycle.
// [R7] Interrupt enable bits 3-6 gate the four compare events.
// [R8] One-shot flag bit 2 latches until cleared by the clear register.
// [R9] Cycle-by-cycle flag bit 1 sets again if trip persists at clear.
// [R10] Cycle-by-cycle output trip releases only at counter zero, trip gone.
// [R11] Flags bits 3-6 latch the four compare event trips.
// [R12] Interrupt flag bit 0 set on pulse; blocks further pulses while set.
// [R13] Clearing interrupt flag with other flags set emits another pulse.
// [R14] With all flags clear, no pulses until a new enabled trip.
// [R15] Clear bits 3-6 write-one clears compare event trips; read zero.
// [R16] Clear bit 2 clears one-shot latch, bit 1 cycle-by-cycle flag only; read zero.
// [R17] Clear bit 0 clears the interrupt flag; reads zero.
// [R18] One-shot trip latched until cleared; any enabled source low sets it.
// [R19] Force bit 2 one-shot, bit 1 cycle-by-cycle trip, setting flags.
// [R20] Force bits 3-6 force compare event trips and set flags.
// [R21] Competing actions resolve: hi-z first, then low, then high.
//
`default_nettype none

package ptp_pkg;

  // ****************************************************
  // Register map (word offsets, byte address = 4 * index)
  // ****************************************************
  localparam logic [2:0] PTP_IDX_SELECT = 3'h0;
  localparam logic [2:0] PTP_IDX_ACTION = 3'h1;
  localparam logic [2:0] PTP_IDX_INT_EN = 3'h2;
  localparam logic [2:0] PTP_IDX_FLAGS = 3'h3;
  localparam logic [2:0] PTP_IDX_CLEAR = 3'h4;
  localparam logic [2:0] PTP_IDX_FORCE = 3'h5;

  localparam int PTP_REG_W = 16;
  localparam logic [15:0] PTP_RST_VAL = 16'h0000;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int PTP_BIT_INT = 0;
  localparam int PTP_BIT_CYC = 1;
  localparam int PTP_BIT_ONE = 2;
  localparam int PTP_BIT_EV_LO = 3;
  localparam int PTP_N_EV = 4;
  localparam int PTP_N_TRIP = 6;
  localparam int PTP_SEL_ONE_LO = 8;
  localparam int PTP_ACT_A_LO = 0;
  localparam int PTP_ACT_B_LO = 2;
  localparam int PTP_ACT_EVA1_LO = 4;
  localparam int PTP_ACT_EVA2_LO = 6;
  localparam int PTP_ACT_EVB1_LO = 8;
  localparam int PTP_ACT_EVB2_LO = 10;
  localparam logic [15:0] PTP_ACT_MASK = 16'h0fff;
  localparam logic [15:0] PTP_SEL_MASK = 16'h3f3f;
  localparam logic [15:0] PTP_INT_EN_MASK = 16'h007e;

  // ****************************************************
  // Action codes
  // ****************************************************
  localparam logic [1:0] PTP_ACT_HIZ = 2'h0;
  localparam logic [1:0] PTP_ACT_HIGH = 2'h1;
  localparam logic [1:0] PTP_ACT_LOW = 2'h2;
  localparam logic [1:0] PTP_ACT_NONE = 2'h3;

  localparam logic [15:0] PTP_CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PTP_BUS_IDLE = 2'b01,
    PTP_BUS_ACK = 2'b10
  } ptp_bus_state_t;

endpackage

`default_nettype wire

// [ptp_out_ctl.sv]
`default_nettype none

// Resolves the active trip actions for one output and drives the pin.
module ptp_out_ctl
  import ptp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pwm_i,
  input wire logic [1:0] act_trip_i,
  input wire logic trip_on_i,
  input wire logic [1:0] act_ev1_i,
  input wire logic ev1_on_i,
  input wire logic [1:0] act_ev2_i,
  input wire logic ev2_on_i,
  output logic pin_o,
  output logic pin_oe_n_o
);

  logic [2:0] hiz_v;
  logic [2:0] low_v;
  logic [2:0] high_v;
  logic want_hiz;
  logic want_low;
  logic want_high;
  logic nxt_pin;
  logic nxt_oe_n;
  logic pin_ff;
  logic oe_n_ff;

  assign hiz_v[0] = trip_on_i && (act_trip_i == PTP_ACT_HIZ);
  assign hiz_v[1] = ev1_on_i && (act_ev1_i == PTP_ACT_HIZ);
  assign hiz_v[2] = ev2_on_i && (act_ev2_i == PTP_ACT_HIZ);
  assign low_v[0] = trip_on_i && (act_trip_i == PTP_ACT_LOW);
  assign low_v[1] = ev1_on_i && (act_ev1_i == PTP_ACT_LOW);
  assign low_v[2] = ev2_on_i && (act_ev2_i == PTP_ACT_LOW);
  assign high_v[0] = trip_on_i && (act_trip_i == PTP_ACT_HIGH);
  assign high_v[1] = ev1_on_i && (act_ev1_i == PTP_ACT_HIGH);
  assign high_v[2] = ev2_on_i && (act_ev2_i == PTP_ACT_HIGH);
  assign want_hiz = |hiz_v;
  assign want_low = |low_v;
  assign want_high = |high_v;

  // Priority keeps the safest state when actions disagree.
  assign nxt_oe_n = want_hiz; // [R21]
  assign nxt_pin = want_hiz ? 1'b0 :
                   want_low ? 1'b0 :
                   want_high ? 1'b1 : pwm_i; // [R21]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_ff <= 1'b0;
      oe_n_ff <= 1'b0;
    end
    else
    begin
      pin_ff <= nxt_pin;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign pin_o = pin_ff;
  assign pin_oe_n_o = oe_n_ff;

endmodule

`default_nettype wire

// [ptp_trip_props.sv]
`default_nettype none
// ****
// Port checks
// ****
module ptp_trip_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [ptp_pkg::PTP_N_TRIP-1:0] trip_input_n_i,
  input wire logic [15:0] time_base_counter_i,
  input wire logic trip_interrupt_pulse_o,
  input wire logic cycle_trip_active_o,
  input wire logic one_shot_trip_active_o
);
  import ptp_pkg::*;
  logic quiet;
  assign quiet = &trip_input_n_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_once_a: assert property (req_s |=> ack_s)
    else $error("ack not a single pulse");
  upper_zero_a: assert property (wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half set");
  dat_hold_a: assert property (!wb_ack_o && !$past(rst_i)
    |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  int_gap_a: assert property (trip_interrupt_pulse_o |=>
    !trip_interrupt_pulse_o)
    else $error("interrupt pulse repeated");
  cyc_rel_a: assert property ($fell(cycle_trip_active_o) &&
    !$past(rst_i) |-> $past(time_base_counter_i) == PTP_CNT_ZERO)
    else $error("cycle hold left off counter zero");
  // A trip needs two sync edges and a hold edge; a force write is quicker.
  cyc_set_a: assert property ($rose(cycle_trip_active_o) && !$past(rst_i)
    |-> !$past(quiet, 3) || !$past(quiet, 4) || wb_ack_o
    || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("cycle hold rose without cause");
  one_set_a: assert property ($rose(one_shot_trip_active_o) &&
    !$past(rst_i) |-> !$past(quiet, 3) || !$past(quiet, 4) || wb_ack_o
    || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("one-shot hold rose without cause");
  one_hold_a: assert property ($fell(one_shot_trip_active_o) &&
    !$past(rst_i) |-> wb_ack_o || $past(wb_ack_o))
    else $error("one-shot hold dropped without a write");
endmodule
bind ptp_trip_top ptp_trip_props u_ptp_trip_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .trip_input_n_i(trip_input_n_i), .time_base_counter_i(time_base_counter_i),
  .trip_interrupt_pulse_o(trip_interrupt_pulse_o),
  .cycle_trip_active_o(cycle_trip_active_o),
  .one_shot_trip_active_o(one_shot_trip_active_o)
);
`default_nettype wire

// [ptp_far_side.sv]
`default_nettype none
// ****
// Time base and gate driver
// ****
module ptp_far_side (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic pin_a_i,
  input wire logic oe_n_a_i,
  input wire logic pin_b_i,
  input wire logic oe_n_b_i,
  output logic [15:0] cnt_o,
  output logic pad_a_o,
  output logic pad_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // The count wraps at 16 so that zero comes round in a short run.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_o <= 16'h0001;
    else if (run_i)
      cnt_o <= {12'h000, cnt_o[3:0] + 4'h1};
  end
  // The driver inputs have pull-downs, so a released pin reads low.
  assign pad_a_o = oe_n_a_i ? 1'b0 : pin_a_i;
  assign pad_b_o = oe_n_b_i ? 1'b0 : pin_b_i;
endmodule
`default_nettype wire

// [test_ptp_trip_top.sv]
`default_nettype none
// ****
// Bench
// ****
module test_ptp_trip_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ptp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic run = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h00000000;
  logic [5:0] trip_n = 6'h3f;
  logic [3:0] ev = 4'h0;
  logic [31:0] rdat;
  logic [15:0] cnt, a;
  logic [1:0] c;
  logic ack, pa, pa_oe, pb, pb_oe, irq, cyc_act, one_act, pad_a, pad_b;
  int bad_count = 0;
  int total_checks = 0;
  int pulses = 0;
  int i;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (irq === 1'b1)
      pulses++;
  ptp_trip_top u_ptp_trip_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .trip_input_n_i(trip_n),
    .compare_event_i(ev), .time_base_counter_i(cnt), .pwm_a_i(1'b1),
    .pwm_b_i(1'b0), .pulse_output_a_o(pa), .pulse_output_a_oe_n_o(pa_oe),
    .pulse_output_b_o(pb), .pulse_output_b_oe_n_o(pb_oe),
    .trip_interrupt_pulse_o(irq), .cycle_trip_active_o(cyc_act),
    .one_shot_trip_active_o(one_act));
  ptp_far_side u_ptp_far_side (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .pin_a_i(pa),
    .oe_n_a_i(pa_oe), .pin_b_i(pb), .oe_n_b_i(pb_oe), .cnt_o(cnt),
    .pad_a_o(pad_a), .pad_b_o(pad_b));
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmpb(input string nm, input logic e, input logic g);
    cmp(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [2:0] ix,
    input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    dat <= {16'h0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    cmpb("ack", 1'b1, ack);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [2:0] ix, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, ix, d, q);
  endtask
  task automatic rd(input logic [2:0] ix, input logic [15:0] e, string nm);
    logic [15:0] q;
    wb(1'b0, ix, 16'h0000, q);
    cmp(nm, e, q);
  endtask
  task automatic pins(input logic [1:0] ca, input logic [1:0] cb);
    cmpb("oe_a", ca == PTP_ACT_HIZ, pa_oe);
    cmpb("pad_a", ca == PTP_ACT_HIGH || ca == PTP_ACT_NONE, pad_a);
    cmpb("oe_b", cb == PTP_ACT_HIZ, pb_oe);
    cmpb("pad_b", cb == PTP_ACT_HIGH, pad_b);
  endtask
  // Running 16 counts returns the time base to 1 after passing zero.
  // The extra edge lets the hold released at zero settle before a check.
  task automatic park;
    run <= 1'b1;
    pause(16);
    run <= 1'b0;
    pause(1);
  endtask
  initial
  begin
    pause(20000);
    bad_count++;
    finish_test;
  end
  initial
  begin
    pause(5);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++)
      rd(i[2:0], PTP_RST_VAL, "reset");
    wr(PTP_IDX_SELECT, 16'hffff);
    rd(PTP_IDX_SELECT, PTP_SEL_MASK, "select");
    wr(PTP_IDX_INT_EN, 16'hffff);
    rd(PTP_IDX_INT_EN, PTP_INT_EN_MASK, "int_en");
    wr(3'h6, 16'hffff);
    rd(3'h6, 16'h0000, "unmapped");
    wr(PTP_IDX_INT_EN, 16'h0000);
    for (i = 0; i < PTP_N_TRIP; i++)
    begin
      c = i[1:0];
      wr(PTP_IDX_SELECT, 16'h0001 << i);
      wr(PTP_IDX_ACTION, {4'h0, 8'hff, c, c});
      trip_n <= ~(6'h01 << i);
      pause(8);
      pins(c, c);
      rd(PTP_IDX_FLAGS, 16'h0002, "flags");
      trip_n <= 6'h3f;
      pause(6);
      wr(PTP_IDX_CLEAR, 16'h0002);
      rd(PTP_IDX_FLAGS, 16'h0000, "flags");
      cmpb("cyc_hold", 1'b1, cyc_act);
      park;
      cmpb("cyc_hold", 1'b0, cyc_act);
    end
    wr(PTP_IDX_SELECT, 16'h0000);
    trip_n <= 6'h00;
    pause(8);
    cmpb("cyc_hold", 1'b0, cyc_act);
    trip_n <= 6'h3f;
    for (i = 0; i < PTP_N_EV; i++)
    begin
      c = (i < 2) ? PTP_ACT_LOW : PTP_ACT_HIGH;
      a = (16'h0fff & ~(16'h0003 << (4 + 2 * i)))
          | ({14'h0, c} << (4 + 2 * i));
      wr(PTP_IDX_ACTION, a);
      wr(PTP_IDX_INT_EN, 16'h0008 << i);
      ev <= 4'h1 << i;
      pause(8);
      pins(i < 2 ? c : 2'h3, i < 2 ? 2'h3 : c);
      ev <= 4'h0;
      pause(6);
      rd(PTP_IDX_FLAGS, (16'h0008 << i) | 16'h0001, "flags");
      wr(PTP_IDX_CLEAR, (16'h0008 << i) | 16'h0001);
      pause(4);
      rd(PTP_IDX_FLAGS, 16'h0000, "flags");
      pins(2'h3, 2'h3);
    end
    cmp("pulses", 16'h0004, pulses[15:0]);
    wr(PTP_IDX_INT_EN, 16'h0000);
    for (i = 0; i < 2; i++)
    begin
      wr(PTP_IDX_ACTION, i ? 16'h0f8f : 16'h0f6f);
      ev <= 4'h3;
      pause(8);
      pins(i ? PTP_ACT_HIZ : PTP_ACT_LOW, 2'h3);
      ev <= 4'h0;
      pause(6);
      wr(PTP_IDX_CLEAR, 16'h0018);
      pause(4);
    end
    wr(PTP_IDX_SELECT, 16'h0100);
    wr(PTP_IDX_ACTION, 16'h0ffe);
    trip_n <= 6'h3e;
    pause(4);
    trip_n <= 6'h3f;
    pause(8);
    park;
    cmpb("one_hold", 1'b1, one_act);
    pins(PTP_ACT_LOW, 2'h3);
    rd(PTP_IDX_FLAGS, 16'h0004, "flags");
    wr(PTP_IDX_CLEAR, 16'h0004);
    pause(3);
    cmpb("one_hold", 1'b0, one_act);
    rd(PTP_IDX_FLAGS, 16'h0000, "flags");
    wr(PTP_IDX_SELECT, 16'h0000);
    wr(PTP_IDX_FORCE, 16'h007e);
    rd(PTP_IDX_FORCE, 16'h0000, "force");
    rd(PTP_IDX_FLAGS, 16'h007e, "flags");
    cmpb("one_hold", 1'b1, one_act);
    wr(PTP_IDX_CLEAR, 16'h007e);
    rd(PTP_IDX_CLEAR, 16'h0000, "clear");
    rd(PTP_IDX_FLAGS, 16'h0000, "flags");
    wr(PTP_IDX_SELECT, 16'h0001);
    wr(PTP_IDX_INT_EN, 16'h0002);
    trip_n <= 6'h3e;
    pause(8);
    cmp("pulses", 16'h0005, pulses[15:0]);
    rd(PTP_IDX_FLAGS, 16'h0003, "flags");
    wr(PTP_IDX_CLEAR, 16'h0001);
    pause(4);
    cmp("pulses", 16'h0006, pulses[15:0]);
    wr(PTP_IDX_CLEAR, 16'h0002);
    rd(PTP_IDX_FLAGS, 16'h0003, "flags");
    trip_n <= 6'h3f;
    pause(6);
    wr(PTP_IDX_CLEAR, 16'h0003);
    pause(6);
    cmp("pulses", 16'h0006, pulses[15:0]);
    rd(PTP_IDX_FLAGS, 16'h0000, "flags");
    wr(PTP_IDX_INT_EN, 16'h0004);
    wr(PTP_IDX_FORCE, 16'h0004);
    pause(4);
    cmp("pulses", 16'h0007, pulses[15:0]);
    rd(PTP_IDX_FLAGS, 16'h0005, "flags");
    wr(PTP_IDX_CLEAR, 16'h0005);
    rd(PTP_IDX_FLAGS, 16'h0000, "flags");
    finish_test;
  end
endmodule
`default_nettype wire
